// ---- scc_defs.svh ----
/*
 holds the register indices, flag bit positions, write masks and reset values of the
 seconds calendar clock; assumes it is included once each by the package, the top and the bench
*/
`ifndef SCC_DEFS_SVH
`define SCC_DEFS_SVH

// timebase
`define SCC_TB_HZ 32768
`define SCC_SUB_W 15

// register word indices on the plain register port
`define SCC_A_CTRL 4'h0
`define SCC_A_TIME 4'h1
`define SCC_A_DATE 4'h2
`define SCC_A_SUB 4'h3
`define SCC_A_CMD 4'h4
`define SCC_A_RULE 4'h5
`define SCC_A_WPAR 4'h6
`define SCC_A_SPAR 4'h7
`define SCC_A_STAT 4'h8
`define SCC_A_MASK 4'h9
`define SCC_A_CAUSE 4'hA

// control, command, status, rule and cause bit positions
`define SCC_CTRL_RUN 0
`define SCC_CTRL_PUSH 1
`define SCC_CTRL_BIND 2
`define SCC_CMD_ZERO 0
`define SCC_ST_TICK 0
`define SCC_ST_SHIFT 1
`define SCC_ST_EDIT 2
`define SCC_RULE_SUMMER 6
`define SCC_CAUSE_EXT 8

// writable bits of the time, date and rule parameter words
`define SCC_TIME_WMASK 32'h071F3F3F
`define SCC_DATE_WMASK 32'hFFFF0F1F
`define SCC_PAR_WMASK 32'h0007FFFF

// reset values
`define SCC_CTRL_RST 3'h1
`define SCC_TIME_RST 32'h07000000
`define SCC_DATE_RST 32'h00000101
`define SCC_RULE_POR 7'h1A
`define SCC_WPAR_RST 19'h21193
`define SCC_SPAR_RST 19'h2219A

`endif

// ---- scc_pkg.sv ----
/*
 holds the types of the seconds calendar clock: time, date and rule layouts and the
 state record; assumes scc_defs.svh is on the include path
*/
`include "scc_defs.svh"

package scc_pkg;

   typedef struct packed {
      logic [4:0] rsv3;
      logic [2:0] dow;
      logic [2:0] rsv2;
      logic [4:0] hour;
      logic [1:0] rsv1;
      logic [5:0] min;
      logic [1:0] rsv0;
      logic [5:0] sec;
   } scc_time_s;

   typedef struct packed {
      logic [15:0] year;
      logic [3:0] rsv1;
      logic [3:0] month;
      logic [2:0] rsv0;
      logic [4:0] date;
   } scc_date_s;

   // one seasonal rule entry; dow 7 means match on the exact date only, no weekday test
   typedef struct packed {
      logic [1:0] shift;
      logic [4:0] hour;
      logic [2:0] dow;
      logic [4:0] date;
      logic [3:0] month;
   } scc_par_s;

   typedef struct packed {
      logic osc_s1;
      logic osc_s2;
      logic osc_s3;
      logic tb_lvl;
      logic [`SCC_SUB_W-1:0] sub;
      logic [2:0] ctrl;
      scc_time_s tm;
      scc_date_s dt;
      logic [6:0] rule;
      scc_par_s wpar;
      scc_par_s spar;
      logic [2:0] stat;
      logic [2:0] mask;
      logic [7:0] cause;
      logic irq;
      logic [31:0] rdata;
      scc_time_s disp_tm;
      scc_date_s disp_dt;
      logic disp_upd;
      logic push_out;
   } scc_state_s;

endpackage

// ---- scc_top.sv ----
/*
 seconds calendar clock: 32768 Hz timebase, sub-second count, time and date record,
 hourly seasonal shift rule, bound display control, reset cause and interrupt.
 assumes osc_32k is a free running pin from outside the ref_clk domain, and that
 the register master, edit inputs and cause inputs are synchronous to ref_clk.
*/
// The plain strobed port and the register addresses were chosen for this implementation.
// Overview of operation
// - count 32768 Hz timebase; a full count raises one second event
// - run setting clear: time frozen, no client push, no tick flag
// - on second event update time and set tick flag in the same step; software clears it
// - day of week in bits 24..26, Sunday..Saturday 0..6, 7 unknown
// - sub-second count loadable and readable, 0..32767, zero command provided
// - bound display control refreshed every second
// - push setting set: push bound value to client each second, else not
// - user edit of bound control loads that time into the record
// - hourly test of seasonal rule; on match shift clock and swap season
// - rule bit 6 set is summer (retard), clear is winter (advance)
// - fixed default rule loaded at reset; software may rewrite it later
// - weekday rule fires first such weekday on or after month/date, at hour
// - separate reset cause indicators; none set means external reset pin
`include "scc_defs.svh"

module scc_top #(
   parameter int TB_HZ = `SCC_TB_HZ
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // timebase pin
   input wire logic osc_32k,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // interrupt
   output logic irq,
   // bound date-time control
   output scc_pkg::scc_time_s disp_time,
   output scc_pkg::scc_date_s disp_date,
   output logic disp_update,
   output logic client_push,
   input wire logic ctl_edit,
   input wire scc_pkg::scc_time_s edit_time,
   input wire scc_pkg::scc_date_s edit_date,
   // reset cause indicators
   input wire logic cause_power_on,
   input wire logic cause_stack_over,
   input wire logic cause_stack_under,
   input wire logic cause_soft_reset,
   input wire logic cause_sleep_wake,
   input wire logic cause_wdog_reset,
   input wire logic cause_wdog_wake,
   input wire logic cause_brown_out
);
   import scc_pkg::*;

   if (TB_HZ < 2 || TB_HZ > (1 << `SCC_SUB_W))
   begin : g_bad_tb
      $error("scc_top: TB_HZ out of range");
   end

   localparam logic [`SCC_SUB_W-1:0] SUB_TOP = `SCC_SUB_W'(TB_HZ - 1);
   localparam scc_state_s RST = '{
      osc_s1: 1'b0, osc_s2: 1'b0, osc_s3: 1'b0, tb_lvl: 1'b0,
      sub: '0, ctrl: `SCC_CTRL_RST,
      tm: scc_time_s'(`SCC_TIME_RST), dt: scc_date_s'(`SCC_DATE_RST),
      rule: `SCC_RULE_POR,
      wpar: scc_par_s'(`SCC_WPAR_RST), spar: scc_par_s'(`SCC_SPAR_RST),
      stat: '0, mask: '0, cause: '0, irq: 1'b0, rdata: '0,
      disp_tm: scc_time_s'(`SCC_TIME_RST), disp_dt: scc_date_s'(`SCC_DATE_RST),
      disp_upd: 1'b0, push_out: 1'b0
   };

   scc_state_s q;
   scc_state_s n;
   logic tb_edge;
   logic sec_evt;
   logic shift_fire;
   logic wr_time;
   logic [2:0] st_clr;
   logic [2:0] st_set;
   scc_time_s t;
   scc_date_s d;
   scc_par_s par;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] idx);
      return a == idx;
   endfunction

   function automatic logic [4:0] hr_move(input logic [4:0] h, input logic [1:0] s,
                                         input logic back);
      logic [5:0] v;
      v = back ? ({1'b0, h} + 6'h18 - {4'h0, s}) : ({1'b0, h} + {4'h0, s});
      if (v >= 6'h18)
      begin
         v = v - 6'h18;
      end
      return v[4:0];
   endfunction

   function automatic logic rule_match(input scc_par_s p, input scc_time_s tt,
                                       input scc_date_s dd);
      logic day_ok;
      day_ok = 1'b0;
      if (p.dow == 3'h7)
      begin
         day_ok = dd.date == p.date;
      end
      else
      begin
         day_ok = (tt.dow == p.dow) && (dd.date >= p.date)
                  && ({1'b0, dd.date} < ({1'b0, p.date} + 6'h07));
      end
      return day_ok && (dd.month == p.month) && (tt.hour == p.hour);
   endfunction

   assign wr_time = reg_wr && (hit(reg_addr, `SCC_A_TIME) || hit(reg_addr, `SCC_A_DATE));

   always_comb
   begin
      n = q;
      t = q.tm;
      d = q.dt;
      shift_fire = 1'b0;
      st_clr = '0;
      st_set = '0;
      par = q.rule[`SCC_RULE_SUMMER] ? q.spar : q.wpar;
      // three-stage pin sampler; a level counts when stages two and three agree
      n.osc_s1 = osc_32k;
      n.osc_s2 = q.osc_s1;
      n.osc_s3 = q.osc_s2;
      if (q.osc_s2 == q.osc_s3)
      begin
         n.tb_lvl = q.osc_s3;
      end
      tb_edge = (q.osc_s2 == q.osc_s3) && q.osc_s3 && !q.tb_lvl;
      sec_evt = q.ctrl[`SCC_CTRL_RUN] && tb_edge && (q.sub == SUB_TOP);
      if (q.ctrl[`SCC_CTRL_RUN] && tb_edge)
      begin
         n.sub = sec_evt ? '0 : q.sub + `SCC_SUB_W'(1);
      end
      n.disp_upd = 1'b0;
      n.push_out = 1'b0;
      n.rdata = '0;
      if (sec_evt)
      begin
         if (t.sec == 6'h3B)
         begin
            t.sec = 6'h00;
            if (t.min == 6'h3B)
            begin
               t.min = 6'h00;
               if (t.hour == 5'h17)
               begin
                  t.hour = 5'h00;
                  if (t.dow != 3'h7)
                  begin
                     t.dow = (t.dow == 3'h6) ? 3'h0 : t.dow + 3'h1;
                  end
                  if (d.date == 5'h1F)
                  begin
                     d.date = 5'h01;
                     if (d.month == 4'hC)
                     begin
                        d.month = 4'h1;
                        d.year = d.year + 16'h0001;
                     end
                     else
                     begin
                        d.month = d.month + 4'h1;
                     end
                  end
                  else
                  begin
                     d.date = d.date + 5'h01;
                  end
               end
               else
               begin
                  t.hour = t.hour + 5'h01;
               end
            end
            else
            begin
               t.min = t.min + 6'h01;
            end
         end
         else
         begin
            t.sec = t.sec + 6'h01;
         end
         // hourly rule test; code zero never fires
         if (t.min == 6'h00 && t.sec == 6'h00 && q.rule != 7'h00 && rule_match(par, t, d))
         begin
            shift_fire = 1'b1;
            // summer retards, winter advances; then swap season
            t.hour = hr_move(t.hour, par.shift, q.rule[`SCC_RULE_SUMMER]);
            n.rule = q.rule ^ (7'h01 << `SCC_RULE_SUMMER);
            st_set[`SCC_ST_SHIFT] = 1'b1;
         end
         n.tm = t;
         n.dt = d;
         // record updated in the same step that raises the tick flag
         st_set[`SCC_ST_TICK] = 1'b1;
         if (q.ctrl[`SCC_CTRL_BIND])
         begin
            n.disp_tm = t;
            n.disp_dt = d;
            n.disp_upd = 1'b1;
            n.push_out = q.ctrl[`SCC_CTRL_PUSH];
         end
      end
      // user edit overrides the second update
      if (q.ctrl[`SCC_CTRL_BIND] && ctl_edit)
      begin
         n.tm = scc_time_s'(edit_time & `SCC_TIME_WMASK);
         n.dt = scc_date_s'(edit_date & `SCC_DATE_WMASK);
         st_set[`SCC_ST_EDIT] = 1'b1;
      end
      // register writes win over hardware updates, except status set bits
      if (reg_wr)
      begin
         unique case (reg_addr)
            `SCC_A_CTRL: n.ctrl = reg_wdata[2:0];
            `SCC_A_TIME: n.tm = scc_time_s'(reg_wdata & `SCC_TIME_WMASK);
            `SCC_A_DATE: n.dt = scc_date_s'(reg_wdata & `SCC_DATE_WMASK);
            `SCC_A_SUB: n.sub = reg_wdata[`SCC_SUB_W-1:0];
            `SCC_A_CMD:
            begin
               if (reg_wdata[`SCC_CMD_ZERO])
               begin
                  n.sub = '0;
               end
            end
            // software may replace the rule at any time
            `SCC_A_RULE: n.rule = reg_wdata[6:0];
            `SCC_A_WPAR: n.wpar = scc_par_s'(reg_wdata[18:0]);
            `SCC_A_SPAR: n.spar = scc_par_s'(reg_wdata[18:0]);
            `SCC_A_STAT: st_clr = reg_wdata[2:0];
            `SCC_A_MASK: n.mask = reg_wdata[2:0];
            default:
            begin
            end
         endcase
      end
      // set wins over a write-one clear in the same cycle
      n.stat = (q.stat & ~st_clr) | st_set;
      n.irq = |(q.stat & q.mask);
      n.cause = {cause_brown_out, cause_wdog_wake, cause_wdog_reset, cause_sleep_wake,
                 cause_soft_reset, cause_stack_under, cause_stack_over, cause_power_on};
      if (reg_rd)
      begin
         unique case (reg_addr)
            `SCC_A_CTRL: n.rdata = {29'h0, q.ctrl};
            `SCC_A_TIME: n.rdata = q.tm;
            `SCC_A_DATE: n.rdata = q.dt;
            `SCC_A_SUB: n.rdata = {{(32 - `SCC_SUB_W){1'b0}}, q.sub};
            `SCC_A_RULE: n.rdata = {25'h0, q.rule};
            `SCC_A_WPAR: n.rdata = {13'h0, q.wpar};
            `SCC_A_SPAR: n.rdata = {13'h0, q.spar};
            `SCC_A_STAT: n.rdata = {29'h0, q.stat};
            `SCC_A_MASK: n.rdata = {29'h0, q.mask};
            `SCC_A_CAUSE: n.rdata = {23'h0, q.cause == 8'h00, q.cause};
            default: n.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         q <= RST;
      end
      else
      begin
         q <= n;
      end
   end

   assign reg_rdata = q.rdata;
   assign irq = q.irq;
   assign disp_time = q.disp_tm;
   assign disp_date = q.disp_dt;
   assign disp_update = q.disp_upd;
   assign client_push = q.push_out;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   // a register write or an edit in the same cycle replaces the refreshed time
   sequence s_second_bound;
      sec_evt && q.ctrl[`SCC_CTRL_BIND] && !wr_time && !ctl_edit;
   endsequence
   sequence s_refreshed;
      q.disp_upd && (q.disp_tm.sec == q.tm.sec);
   endsequence

   property p_sec_adv;
      sec_evt && q.tm.sec < 6'h3B && !wr_time && !(q.ctrl[`SCC_CTRL_BIND] && ctl_edit)
      |=> q.tm.sec == $past(q.tm.sec) + 6'h01;
   endproperty
   a_sec_adv: assert property (p_sec_adv) else $error("second did not advance");
   property p_stopped;
      !q.ctrl[`SCC_CTRL_RUN] && !reg_wr |=> q.sub == $past(q.sub) && !q.stat[`SCC_ST_TICK]
         || $past(q.stat[`SCC_ST_TICK]);
   endproperty
   a_stopped: assert property (p_stopped) else $error("clock moved while stopped");
   property p_tick_flag;
      sec_evt |=> q.stat[`SCC_ST_TICK] ##1 (q.irq || !$past(q.mask[`SCC_ST_TICK]));
   endproperty
   a_tick_flag: assert property (p_tick_flag) else $error("tick flag not set");
   property p_dow_unknown;
      q.tm.dow == 3'h7 && !wr_time && !ctl_edit |=> q.tm.dow == 3'h7;
   endproperty
   a_dow_unknown: assert property (p_dow_unknown) else $error("unknown weekday changed");
   property p_sub_zero;
      reg_wr && hit(reg_addr, `SCC_A_CMD) && reg_wdata[`SCC_CMD_ZERO] |=> q.sub == '0;
   endproperty
   a_sub_zero: assert property (p_sub_zero) else $error("sub-second not zeroed");
   property p_refresh;
      s_second_bound |=> s_refreshed;
   endproperty
   a_refresh: assert property (p_refresh) else $error("display not refreshed");
   property p_push;
      client_push |-> disp_update && $past(q.ctrl[`SCC_CTRL_PUSH]);
   endproperty
   a_push: assert property (p_push) else $error("client push without setting");
   property p_edit;
      q.ctrl[`SCC_CTRL_BIND] && ctl_edit && !reg_wr |=> q.tm.hour == $past(edit_time.hour);
   endproperty
   a_edit: assert property (p_edit) else $error("edit not loaded");
   property p_swap;
      shift_fire && !reg_wr |=> q.rule[`SCC_RULE_SUMMER] != $past(q.rule[`SCC_RULE_SUMMER])
         && q.stat[`SCC_ST_SHIFT];
   endproperty
   a_swap: assert property (p_swap) else $error("rule not swapped");
   property p_por_rule;
      $fell(sys_rst) |-> q.rule == `SCC_RULE_POR;
   endproperty
   a_por_rule: assert property (p_por_rule) else $error("rule not at power-on value");
   property p_wday;
      shift_fire && par.dow != 3'h7 && !wr_time && !ctl_edit |=> q.tm.dow == $past(par.dow);
   endproperty
   a_wday: assert property (p_wday) else $error("shift on wrong weekday");
   property p_cause;
      reg_rd && hit(reg_addr, `SCC_A_CAUSE)
         |=> reg_rdata[`SCC_CAUSE_EXT] == ($past(q.cause) == 8'h00);
   endproperty
   a_cause: assert property (p_cause) else $error("external reset cause wrong");

endmodule // scc_top

// ---- scc_tb_top.sv ----
/*
 self-checking bench of the seconds calendar clock: register rows, second rollover,
 run and push gating, seasonal shift, control edit and reset cause.
 assumes scc_top with a short timebase count and the one-cycle register port.
*/
`include "scc_defs.svh"

module scc_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import scc_pkg::*;

   // four timebase edges make a second, so each second costs 64 clocks
   localparam int HZ = 4;
   typedef struct {
      logic w;
      logic [3:0] a;
      logic [31:0] d;
      logic [31:0] e;
   } scc_row_s;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic osc_32k = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic irq;
   scc_time_s disp_time;
   scc_date_s disp_date;
   logic disp_update;
   logic client_push;
   logic ctl_edit = 1'b0;
   scc_time_s edit_time = '0;
   scc_date_s edit_date = '0;
   logic [7:0] cause = 8'h00;
   int err_count = 0;
   int total_checks = 0;
   int cyc = 0;
   int upd_n = 0;
   int push_n = 0;
   logic [31:0] rv;
   scc_row_s rows [16] = '{
      '{1'b0, `SCC_A_CTRL, 32'h0, 32'h1}, '{1'b0, `SCC_A_TIME, 32'h0, 32'h07000000},
      '{1'b0, `SCC_A_DATE, 32'h0, 32'h00000101}, '{1'b0, `SCC_A_SUB, 32'h0, 32'h0},
      '{1'b0, `SCC_A_CMD, 32'h0, 32'h0}, '{1'b0, `SCC_A_RULE, 32'h0, 32'h1A},
      '{1'b0, `SCC_A_WPAR, 32'h0, 32'h21193}, '{1'b0, `SCC_A_SPAR, 32'h0, 32'h2219A},
      '{1'b0, `SCC_A_STAT, 32'h0, 32'h0}, '{1'b0, `SCC_A_MASK, 32'h0, 32'h0},
      '{1'b0, `SCC_A_CAUSE, 32'h0, 32'h100}, '{1'b0, 4'hB, 32'h0, 32'h0},
      '{1'b1, `SCC_A_SUB, 32'hFFFF, 32'h7FFF}, '{1'b1, `SCC_A_CMD, 32'h1, 32'h0},
      '{1'b0, `SCC_A_SUB, 32'h0, 32'h0}, '{1'b1, 4'hB, 32'hFFFFFFFF, 32'h0}};
   // rule, date, time before, time after, rule after
   logic [31:0] sh [4][5] = '{
      '{32'h1A, 32'h07D0031C, 32'h00003B3B, 32'h00020000, 32'h5A},
      '{32'h1A, 32'h07D00318, 32'h00003B3B, 32'h00010000, 32'h1A},
      '{32'h5A, 32'h07D00A19, 32'h00013B3B, 32'h00010000, 32'h1A},
      '{32'h00, 32'h07D0031C, 32'h00003B3B, 32'h00010000, 32'h00}};

   scc_top #(.TB_HZ(HZ)) i_scc_top (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .osc_32k(osc_32k),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq), .disp_time(disp_time), .disp_date(disp_date),
      .disp_update(disp_update), .client_push(client_push), .ctl_edit(ctl_edit),
      .edit_time(edit_time), .edit_date(edit_date),
      .cause_power_on(cause[0]), .cause_stack_over(cause[1]),
      .cause_stack_under(cause[2]), .cause_soft_reset(cause[3]),
      .cause_sleep_wake(cause[4]), .cause_wdog_reset(cause[5]),
      .cause_wdog_wake(cause[6]), .cause_brown_out(cause[7]));

   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
      chk(nm, e, rv);
   endtask

   // zero the sub-second count, then give exactly one second of timebase edges
   task automatic second;
      wr(`SCC_A_CMD, 32'h1);
      upd_n = 0;
      push_n = 0;
      repeat (HZ)
      begin
         @(posedge ref_clk);
         osc_32k <= 1'b1;
         repeat (8) @(posedge ref_clk);
         osc_32k <= 1'b0;
         repeat (7) @(posedge ref_clk);
      end
   endtask

   always @(posedge ref_clk)
   begin
      cyc++;
      if (disp_update === 1'b1)
         upd_n++;
      if (client_push === 1'b1)
         push_n++;
      if (cyc == 4000)
      begin
         err_count++;
         close_out();
      end
   end

   initial
   begin
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      foreach (rows[i])
      begin
         if (rows[i].w)
            wr(rows[i].a, rows[i].d);
         rchk($sformatf("reg %h", rows[i].a), rows[i].a, rows[i].e);
      end
      $display("test table done");
      wr(`SCC_A_CTRL, 32'h7);
      wr(`SCC_A_TIME, 32'h06173B3B);
      wr(`SCC_A_DATE, 32'h07CF0C1F);
      rchk("dow", `SCC_A_TIME, 32'h06173B3B);
      second();
      rchk("time", `SCC_A_TIME, 32'h00000000);
      rchk("date", `SCC_A_DATE, 32'h07D00101);
      chk("disp_date", 32'h07D00101, disp_date);
      chk("disp_time", 32'h00000000, disp_time);
      chk("updates", 32'h1, 32'(upd_n));
      chk("pushes", 32'h1, 32'(push_n));
      rchk("stat", `SCC_A_STAT, 32'h1);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(`SCC_A_MASK, 32'h1);
      @(posedge ref_clk);
      #1 chk("irq", 32'h1, {31'h0, irq});
      wr(`SCC_A_STAT, 32'h1);
      @(posedge ref_clk);
      #1 chk("irq cleared", 32'h0, {31'h0, irq});
      $display("test rollover done");
      wr(`SCC_A_CTRL, 32'h6);
      wr(`SCC_A_MASK, 32'h0);
      wr(`SCC_A_TIME, 32'h00010203);
      wr(`SCC_A_MASK, 32'h1);
      second();
      rchk("frozen", `SCC_A_TIME, 32'h00010203);
      rchk("no tick", `SCC_A_STAT, 32'h0);
      chk("no push", 32'h0, 32'(push_n));
      wr(`SCC_A_CTRL, 32'h5);
      second();
      chk("updates", 32'h1, 32'(upd_n));
      chk("push off", 32'h0, 32'(push_n));
      $display("test gating done");
      for (int i = 0; i < 4; i++)
      begin
         wr(`SCC_A_MASK, 32'h0);
         wr(`SCC_A_RULE, sh[i][0]);
         wr(`SCC_A_DATE, sh[i][1]);
         wr(`SCC_A_TIME, sh[i][2]);
         wr(`SCC_A_MASK, 32'h1);
         wr(`SCC_A_STAT, 32'h7);
         second();
         rchk("shift time", `SCC_A_TIME, sh[i][3]);
         rchk("rule", `SCC_A_RULE, sh[i][4]);
         rchk("shift stat", `SCC_A_STAT, (sh[i][0] != sh[i][4]) ? 32'h3 : 32'h1);
      end
      $display("test seasonal done");
      wr(`SCC_A_STAT, 32'h7);
      @(posedge ref_clk);
      ctl_edit <= 1'b1;
      edit_time <= 32'h03121E05;
      edit_date <= 32'h07D0060F;
      @(posedge ref_clk);
      ctl_edit <= 1'b0;
      rchk("edit time", `SCC_A_TIME, 32'h03121E05);
      rchk("edit date", `SCC_A_DATE, 32'h07D0060F);
      rchk("edit stat", `SCC_A_STAT, 32'h4);
      $display("test edit done");
      for (int i = 0; i < 8; i++)
      begin
         @(posedge ref_clk);
         cause <= 8'h01 << i;
         rchk("cause", `SCC_A_CAUSE, 32'h1 << i);
      end
      $display("test cause done");
      // mid-run reset must bring back the power-on rule and time
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rchk("reset rule", `SCC_A_RULE, 32'h1A);
      rchk("reset time", `SCC_A_TIME, 32'h07000000);
      $display("test reset done");
      close_out();
   end
endmodule // scc_tb_top
